// [hdl/mlab_defines.vh]
// constants for the logic array block: map, field positions, encodings
// assumes inclusion by every design file of the block
`ifndef MLAB_DEFINES_VH
`define MLAB_DEFINES_VH

`define MLAB_NUM_MC        16
`define MLAB_PT_PER_MC     5
`define MLAB_ROW_W         33
`define MLAB_SIG_W         114
`define MLAB_MASK_WORDS    4
`define MLAB_MEM_WORDS     9'h151
`define MLAB_MEM_BITS      10784
`define MLAB_CHAIN_LEN     8
`define MLAB_MAX_SETS      3

// word indices, byte address is index times four
`define MLAB_MC_CFG_BASE   9'h140
`define MLAB_GLB_IDX       9'h150
`define MLAB_STAT_IDX      9'h151

// macrocell configuration word
`define MLAB_F_RTYPE       2:0
`define MLAB_F_CKMODE      4:3
`define MLAB_F_GCSEL       5
`define MLAB_F_GCLR        6
`define MLAB_F_PACK        7
`define MLAB_F_ROW         8
`define MLAB_F_COL         9
`define MLAB_F_ROLE_LSB    10
`define MLAB_F_XOR         25
`define MLAB_F_NSETS       27:26

`define MLAB_RT_D          3'h0
`define MLAB_RT_T          3'h1
`define MLAB_RT_JK         3'h2
`define MLAB_RT_SR         3'h3
`define MLAB_RT_BYP        3'h4

`define MLAB_CK_GLOBAL     2'h0
`define MLAB_CK_GLOBAL_ENA 2'h1
`define MLAB_CK_ARRAY      2'h2

`define MLAB_ROLE_LOGIC    3'h0
`define MLAB_ROLE_CLR      3'h1
`define MLAB_ROLE_PRE      3'h2
`define MLAB_ROLE_CLK      3'h3
`define MLAB_ROLE_ENA      3'h4
`define MLAB_ROLE_SEXP     3'h5
`define MLAB_ROLE_LEND     3'h6
`define MLAB_ROLE_SEC      3'h7

// global configuration word
`define MLAB_G_GC0_SRC     0
`define MLAB_G_GC0_INV     1
`define MLAB_G_GC1_SRC     2
`define MLAB_G_GC1_INV     3
`define MLAB_G_GCLR_LOW    4
`define MLAB_G_RUN         8

// ahb-lite
`define MLAB_HRESP_OKAY    1'b0

`endif

// [hdl/mlab_cfg_store.v]
// configuration store: product-term masks, macrocell and global words
// assumes one writer and one reader, synchronous reset clears all words
`include "mlab_defines.vh"
`default_nettype none

module mlab_cfg_store (
   input  wire                       sys_clk,
   input  wire                       sys_rst,
   input  wire                       wr_en,
   input  wire [8:0]                 wr_idx,
   input  wire [31:0]                wr_data,
   input  wire [8:0]                 rd_idx,
   output reg  [31:0]                rd_data_r,
   output wire [`MLAB_MEM_BITS-1:0]  cfg_flat
);

   reg [`MLAB_MEM_BITS-1:0] mem_r;

   assign cfg_flat = mem_r;

   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         mem_r     <= {`MLAB_MEM_BITS{1'b0}};
         rd_data_r <= 32'h0000_0000;
      end
      else
      begin
         if (wr_en && (wr_idx < `MLAB_MEM_WORDS))
            mem_r[wr_idx*32 +: 32] <= wr_data;
         if (rd_idx < `MLAB_MEM_WORDS)
            rd_data_r <= mem_r[rd_idx*32 +: 32];
         else
            rd_data_r <= 32'h0000_0000;
      end
   end

endmodule
`default_nettype wire

// [hdl/mlab_macrocell.v]
// one macrocell: select matrix, or/xor logic and programmable register
// assumes product terms and global clock edges already evaluated on sys_clk
`include "mlab_defines.vh"
`default_nettype none

module mlab_macrocell (
   input  wire        sys_clk,
   input  wire        sys_rst,
   input  wire        run,
   input  wire [31:0] cfg,
   input  wire [4:0]  pt,
   input  wire [1:0]  gclk_edge,
   input  wire        gclr_act,
   input  wire        borrow_in,
   output wire        lend_out,
   output wire        sexp_out,
   output wire        prim_out,
   output wire        pack_out
);

   reg        q_r;
   reg        q_nxt;
   reg        ck_pt_prev_r;
   reg        tick;
   wire [2:0] rtype;
   wire       logic_sum;
   wire       comb;
   wire       sec;
   wire       d_in;
   wire       clr;
   wire       pre;
   wire       ck_pt;
   wire       ena_pt;

   function [4:0] role_mask;
      input [31:0] c;
      input [2:0]  r;
      integer      k;
      begin
         for (k = 0; k < `MLAB_PT_PER_MC; k = k + 1)
            role_mask[k] = (c[`MLAB_F_ROLE_LSB + 3*k +: 3] == r);
      end
   endfunction

   assign rtype     = cfg[`MLAB_F_RTYPE];
   // term routing to logic or register controls
   assign logic_sum = (|(pt & role_mask(cfg, `MLAB_ROLE_LOGIC))) | borrow_in;
   assign comb      = logic_sum ^ cfg[`MLAB_F_XOR];
   assign sec       = |(pt & role_mask(cfg, `MLAB_ROLE_SEC));
   assign clr       = (|(pt & role_mask(cfg, `MLAB_ROLE_CLR))) | (cfg[`MLAB_F_GCLR] & gclr_act);
   assign pre       = |(pt & role_mask(cfg, `MLAB_ROLE_PRE));
   assign ck_pt     = |(pt & role_mask(cfg, `MLAB_ROLE_CLK));
   assign ena_pt    = |(pt & role_mask(cfg, `MLAB_ROLE_ENA));
   assign sexp_out  = ~(|(pt & role_mask(cfg, `MLAB_ROLE_SEXP)));
   assign lend_out  = |(pt & role_mask(cfg, `MLAB_ROLE_LEND));
   // packing: one term drives d, logic sum stays combinatorial
   assign d_in      = cfg[`MLAB_F_PACK] ? sec : comb;
   assign pack_out  = cfg[`MLAB_F_PACK] & comb;
   assign prim_out  = (rtype == `MLAB_RT_BYP) ? comb : q_r;

   always @*
   begin
      case (cfg[`MLAB_F_CKMODE])
         `MLAB_CK_GLOBAL:     tick = gclk_edge[cfg[`MLAB_F_GCSEL]];
         `MLAB_CK_GLOBAL_ENA: tick = gclk_edge[cfg[`MLAB_F_GCSEL]] & ena_pt;
         `MLAB_CK_ARRAY:      tick = ck_pt & ~ck_pt_prev_r;
         default:             tick = 1'b0;
      endcase
   end

   always @*
   begin
      case (rtype)
         `MLAB_RT_D:  q_nxt = d_in;
         `MLAB_RT_T:  q_nxt = q_r ^ d_in;
         `MLAB_RT_JK: q_nxt = (d_in & ~q_r) | (~sec & q_r);
         `MLAB_RT_SR: q_nxt = d_in | (~sec & q_r);
         default:     q_nxt = q_r;
      endcase
   end

   always @(posedge sys_clk)
   begin
      if (sys_rst || !run)
      begin
         q_r          <= 1'b0;
         ck_pt_prev_r <= 1'b0;
      end
      else
      begin
         ck_pt_prev_r <= ck_pt;
         if (clr)
            q_r <= 1'b0;
         else if (pre)
            q_r <= 1'b1;
         else if (tick)
            q_r <= q_nxt;
      end
   end

endmodule
`default_nettype wire

// [hdl/mlab_logic_array_block.v]
// logic array block of sixteen macrocells with its local array
// assumes an ahb-lite master for configuration, pins synchronous to sys_clk
//
// The address map and register access over AHB-Lite were chosen for this implementation.
`include "mlab_defines.vh"
`default_nettype none

module mlab_logic_array_block (
   input  wire                   sys_clk,
   input  wire                   sys_rst,
   input  wire                   hsel,
   input  wire [31:0]            haddr,
   input  wire [1:0]             htrans,
   input  wire                   hwrite,
   input  wire [2:0]             hsize,
   input  wire [31:0]            hwdata,
   input  wire                   hready,
   output reg                    hreadyout,
   output reg                    hresp,
   output reg  [31:0]            hrdata,
   input  wire [`MLAB_ROW_W-1:0] row_in,
   input  wire                   global_clock_pin_one,
   input  wire                   global_clock_pin_two,
   input  wire                   global_clear_pin,
   output reg  [15:0]            row_out_r,
   output reg  [15:0]            col_out_r,
   output reg  [15:0]            pack_out_r
);

   // bus side state
   reg         wr_pend_r;
   reg  [8:0]  wr_idx_r;
   reg         wr_bad_r;
   reg         rd1_r;
   reg         rd2_r;
   reg  [8:0]  rd_idx_r;
   reg         rd_bad_r;
   reg  [31:0] stat_r;
   wire        acc;
   wire        idx_ok;
   wire        mem_we;
   wire [31:0] mem_rdata;

   // array side state
   wire [`MLAB_MEM_BITS-1:0] cfg_flat;
   wire [31:0]               glb;
   wire                      run;
   reg  [1:0]                gclk_r;
   reg  [1:0]                gclk_prev_r;
   reg                       gclr_r;
   wire [1:0]                gclk_edge;
   reg  [15:0]               fb_r;
   reg  [15:0]               sexp_r;
   wire [`MLAB_SIG_W-1:0]    sig;
   wire [15:0]               lend;
   wire [15:0]               sexp;
   wire [15:0]               prim;
   wire [15:0]               pack;
   wire [15:0]               row_en;
   wire [15:0]               col_en;

   // and of selected signals; an empty mask yields a false term
   function pt_eval;
      input [`MLAB_SIG_W-1:0] mask;
      input [`MLAB_SIG_W-1:0] s;
      begin
         pt_eval = (|mask) & (&(~mask | s));
      end
   endfunction

   // or of up to three lent sets from consecutive lower neighbours
   function borrow_sum;
      input [15:0] l;
      input integer m;
      input [1:0]  nsets;
      integer      k;
      begin
         borrow_sum = 1'b0;
         for (k = 1; k <= `MLAB_MAX_SETS; k = k + 1)
            if ((k <= nsets) && ((m % `MLAB_CHAIN_LEN) >= k))
               borrow_sum = borrow_sum | l[m-k];
      end
   endfunction

   // ahb-lite slave
   assign acc    = hsel & hready & htrans[1];
   assign idx_ok = (haddr[31:11] == 21'h000000) && (haddr[1:0] == 2'h0);

   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         wr_pend_r <= 1'b0;
         wr_idx_r  <= 9'h000;
         wr_bad_r  <= 1'b0;
         rd1_r     <= 1'b0;
         rd2_r     <= 1'b0;
         rd_idx_r  <= 9'h000;
         rd_bad_r  <= 1'b0;
         hreadyout <= 1'b1;
         hresp     <= `MLAB_HRESP_OKAY;
         hrdata    <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_r <= acc & hwrite;
         rd1_r     <= acc & ~hwrite;
         rd2_r     <= rd1_r;
         if (acc)
         begin
            wr_idx_r <= haddr[10:2];
            wr_bad_r <= ~idx_ok;
            rd_idx_r <= haddr[10:2];
            rd_bad_r <= ~idx_ok;
         end
         if (acc & ~hwrite)
            hreadyout <= 1'b0;
         else if (rd2_r)
            hreadyout <= 1'b1;
         if (rd2_r)
         begin
            if (rd_bad_r)
               hrdata <= 32'h0000_0000;
            else if (rd_idx_r < `MLAB_MEM_WORDS)
               hrdata <= mem_rdata;
            else if (rd_idx_r == `MLAB_STAT_IDX)
               hrdata <= stat_r;
            else
               hrdata <= 32'h0000_0000;
         end
      end
   end

   // writes other than the global word are refused while running
   assign mem_we = wr_pend_r & ~wr_bad_r & (~run | (wr_idx_r == `MLAB_GLB_IDX));

   mlab_cfg_store u_store (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .wr_en     (mem_we),
      .wr_idx    (wr_idx_r),
      .wr_data   (hwdata),
      .rd_idx    (rd_idx_r),
      .rd_data_r (mem_rdata),
      .cfg_flat  (cfg_flat)
   );

   assign glb = cfg_flat[`MLAB_GLB_IDX*32 +: 32];
   assign run = glb[`MLAB_G_RUN];

   // global clocks and clear distributed to every macrocell
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         gclk_r      <= 2'h0;
         gclk_prev_r <= 2'h0;
         gclr_r      <= 1'b0;
      end
      else
      begin
         gclk_r[0]   <= (glb[`MLAB_G_GC0_SRC] ? global_clock_pin_two : global_clock_pin_one)
                        ^ glb[`MLAB_G_GC0_INV];
         gclk_r[1]   <= (glb[`MLAB_G_GC1_SRC] ? global_clock_pin_two : global_clock_pin_one)
                        ^ glb[`MLAB_G_GC1_INV];
         gclk_prev_r <= gclk_r;
         gclr_r      <= global_clear_pin ^ glb[`MLAB_G_GCLR_LOW];
      end
   end

   assign gclk_edge = gclk_r & ~gclk_prev_r;

   // local array: rows and feedback in true and inverted forms, expanders inverted only
   assign sig = {~sexp_r, ~fb_r, fb_r, ~row_in, row_in};

   genvar m;
   generate
      for (m = 0; m < `MLAB_NUM_MC; m = m + 1)
      begin : g_mc
         wire [31:0] mc_cfg;
         wire [4:0]  pt;
         wire        borrow;
         genvar      k;

         assign mc_cfg = cfg_flat[(`MLAB_MC_CFG_BASE + m)*32 +: 32];
         for (k = 0; k < `MLAB_PT_PER_MC; k = k + 1)
         begin : g_pt
            assign pt[k] = pt_eval(
               cfg_flat[((m*`MLAB_PT_PER_MC + k)*`MLAB_MASK_WORDS)*32 +: `MLAB_SIG_W], sig);
         end

         // chain borrow, lowest of each chain of eight cannot borrow, zero-delay model per set
         assign borrow = borrow_sum(lend, m, mc_cfg[`MLAB_F_NSETS]);

         mlab_macrocell u_mc (
            .sys_clk   (sys_clk),
            .sys_rst   (sys_rst),
            .run       (run),
            .cfg       (mc_cfg),
            .pt        (pt),
            .gclk_edge (gclk_edge),
            .gclr_act  (gclr_r),
            .borrow_in (borrow),
            .lend_out  (lend[m]),
            .sexp_out  (sexp[m]),
            .prim_out  (prim[m]),
            .pack_out  (pack[m])
         );

         assign row_en[m] = mc_cfg[`MLAB_F_ROW];
         assign col_en[m] = mc_cfg[`MLAB_F_COL];
      end
   endgenerate

   // feedback, expanders and routing outputs registered once
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         fb_r       <= 16'h0000;
         sexp_r     <= 16'h0000;
         row_out_r  <= 16'h0000;
         col_out_r  <= 16'h0000;
         pack_out_r <= 16'h0000;
         stat_r     <= 32'h0000_0000;
      end
      else
      begin
         fb_r       <= prim;
         sexp_r     <= sexp & {16{run}};
         row_out_r  <= prim & row_en;
         col_out_r  <= prim & col_en;
         pack_out_r <= pack;
         stat_r     <= {sexp_r, fb_r};
      end
   end

endmodule
`default_nettype wire

// [bench/mlab_lab_chk.sv]
// port checker for the logic array block: bus timing and reset values
// assumes hready is fed back from hreadyout by the surroundings
`default_nettype none
module mlab_lab_chk (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic [15:0] row_out_r,
   input wire logic [15:0] col_out_r,
   input wire logic [15:0] pack_out_r
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   wire rd_take = hsel && hready && htrans[1] && !hwrite;
   wire wr_take = hsel && hready && htrans[1] && hwrite;
   property p_okay;
      hresp == 1'b0;
   endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
   property p_rd_wait;
      rd_take |=> !hreadyout ##1 !hreadyout ##1 hreadyout;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait not two cycles");
   property p_wr_zero;
      wr_take |=> hreadyout;
   endproperty
   a_wr_zero: assert property (p_wr_zero) else $error("write was stalled");
   property p_fall_cause;
      $fell(hreadyout) |-> $past(rd_take);
   endproperty
   a_fall_cause: assert property (p_fall_cause) else $error("stall without read");
   property p_low_two;
      $fell(hreadyout) |=> !hreadyout ##1 hreadyout;
   endproperty
   a_low_two: assert property (p_low_two) else $error("stall length wrong");
   property p_hold;
      hreadyout && $past(hreadyout) && !$past(sys_rst) |-> $stable(hrdata);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_unmapped;
      rd_take && haddr[31:11] != 21'h0 |-> ##3 hrdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_reset;
      disable iff (1'b0)
      sys_rst |=> hreadyout && hrdata == 32'h0 && row_out_r == 16'h0 && col_out_r == 16'h0
         && pack_out_r == 16'h0;
   endproperty
   a_reset: assert property (p_reset) else $error("reset values wrong");
   c_rd: cover property (rd_take);
   c_wr: cover property (wr_take);
   c_row: cover property (row_out_r != 16'h0);
endmodule
bind mlab_logic_array_block mlab_lab_chk u_chk (.sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
   .hready, .hreadyout, .hresp, .hrdata, .row_out_r, .col_out_r, .pack_out_r);
`default_nettype wire

// [bench/mlab_route_model.sv]
// routing side model: row inputs and dedicated pins of the block
// assumes changes are launched just after a rising sys_clk edge
`default_nettype none
module mlab_route_model (
   input  wire logic        sys_clk,
   output var  logic [32:0] row_in,
   output var  logic        pin_one,
   output var  logic        pin_two,
   output var  logic        clr_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // full-length lines, each reaches the block directly
   initial
   begin
      row_in = 33'h0;
      pin_one = 1'b0;
      pin_two = 1'b0;
      clr_pin = 1'b0;
   end
   task set_row(input logic [32:0] v);
      @(posedge sys_clk);
      row_in <= v;
   endtask
   task set_clr(input logic v);
      @(posedge sys_clk);
      clr_pin <= v;
   endtask
   task pulse(input logic two);
      @(posedge sys_clk);
      if (two)
         pin_two <= 1'b1;
      else
         pin_one <= 1'b1;
      repeat (2) @(posedge sys_clk);
      pin_one <= 1'b0;
      pin_two <= 1'b0;
   endtask
endmodule
`default_nettype wire

// [bench/mlab_logic_array_block_test.sv]
// self-checking bench for the logic array block
// assumes a 200 MHz clock and the routing model as far side
`default_nettype none
module mlab_logic_array_block_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk;
   logic        sys_rst;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic [32:0] row_in;
   logic        pin_one;
   logic        pin_two;
   logic        clr_pin;
   logic [15:0] row_out_r;
   logic [15:0] col_out_r;
   logic [15:0] pack_out_r;
   logic [31:0] rd;
   int          fails;
   int          n_tests;
   logic [31:0] cfg_a [9] = '{32'h0, 32'h54, 32'ha0, 32'hf0, 32'h500, 32'h504, 32'h508, 32'h50c, 32'h510};
   logic [31:0] cfg_d [9] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h304, 32'h104, 32'h140, 32'h1804, 32'h0400_0104};
   mlab_logic_array_block DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .row_in(row_in),
      .global_clock_pin_one(pin_one), .global_clock_pin_two(pin_two), .global_clear_pin(clr_pin),
      .row_out_r(row_out_r), .col_out_r(col_out_r), .pack_out_r(pack_out_r));
   mlab_route_model u_route (.sys_clk(sys_clk), .row_in(row_in), .pin_one(pin_one),
      .pin_two(pin_two), .clr_pin(clr_pin));
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task mc2(input logic exp, input int n);
      repeat (n) @(posedge sys_clk);
      chk("register out", {31'h0, row_out_r[2]}, {31'h0, exp});
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (5000) @(posedge sys_clk);
      fails++;
      finish_test;
   end
   initial
   begin
      sys_rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      fails = 0;
      n_tests = 0;
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      chk("reset outputs", {row_out_r, col_out_r}, 32'h0);
      for (int i = 0; i < 9; i++)
         ahb(1'b1, cfg_a[i], cfg_d[i]);
      ahb(1'b0, 32'h510, 32'h0);
      chk("cfg readback", rd, 32'h0400_0104);
      ahb(1'b1, 32'h544, 32'hffff_ffff);
      ahb(1'b0, 32'h800, 32'h0);
      chk("unmapped read", rd, 32'h0);
      ahb(1'b1, 32'h540, 32'h100);
      ahb(1'b1, 32'h500, 32'h0);
      ahb(1'b0, 32'h500, 32'h0);
      chk("cfg while running", rd, 32'h304);
      for (int v = 0; v < 2; v++)
      begin
         u_route.set_row(v ? 33'h9 : 33'h0);
         repeat (3) @(posedge sys_clk);
         chk("row out", {16'h0, row_out_r & 16'h13}, v ? 32'h11 : 32'h2);
         chk("col out", {16'h0, col_out_r & 16'h3}, v ? 32'h1 : 32'h0);
      end
      u_route.set_row(33'h4);
      mc2(1'b0, 3);
      u_route.pulse(1'b0);
      mc2(1'b1, 4);
      u_route.set_row(33'h0);
      mc2(1'b1, 3);
      u_route.set_clr(1'b1);
      mc2(1'b0, 4);
      u_route.set_clr(1'b0);
      u_route.set_row(33'h4);
      u_route.pulse(1'b0);
      mc2(1'b1, 4);
      ahb(1'b1, 32'h540, 32'h110);
      mc2(1'b0, 4);
      u_route.set_row(33'h0);
      repeat (3) @(posedge sys_clk);
      ahb(1'b0, 32'h544, 32'h0);
      chk("status", rd, 32'hffff_0002);
      ahb(1'b1, 32'h540, 32'h101);
      u_route.set_row(33'h4);
      u_route.pulse(1'b0);
      mc2(1'b0, 4);
      u_route.pulse(1'b1);
      mc2(1'b1, 4);
      finish_test;
   end
endmodule
`default_nettype wire
